// [rtl/core_timer.sv]
// Module: core timer with overflow flag, periodic flag, watchdog and power-on delay
//
// Function
// - E divided by four clocks readable 8-bit counter
// - Counter register read-only, writes ignored
// - Overflow flag set on counter wrap
// - Overflow flag cleared only by clear bit or a reset
// - Overflow clear bit acts on one, reads zero
// - Overflow enable requests interrupt, reset clears
// - Two more stages give E/4096
// - Periodic flag set by selected divider stage
// - Periodic flag cleared only by clear bit or a reset
// - Periodic clear bit acts on one, reads zero
// - Periodic enable requests interrupt, reset clears
// - Rate field picks 2^12 to 2^15 period
// - Reset selects slowest periodic rate
// - Periodic output divided by eight feeds watchdog
// - Power-on clears chain, again after 4064
// - External reset clears whole chain
// - Watchdog service clears only final stage
// - Watchdog timeout raises internal reset
// - Stop entry drops requests, clears prescaler
// - Timer runs in wait, interrupt wakes
`default_nettype none

module core_timer #(
	parameter bit WATCHDOG_EN = 1'b1
) (
	// Clock and power-on reset
	input  wire logic        clock,
	input  wire logic        reset,
	// External reset pin, active low, asynchronous
	input  wire logic        ext_reset_n,
	// Internal CPU bus
	input  wire logic [13:0] bus_addr,
	input  wire logic        bus_write,
	input  wire logic        bus_read,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata_q,
	// Low-power mode controls from the CPU
	input  wire logic        stop_entry,
	input  wire logic        wait_mode,
	// Status to the core
	output logic             timer_irq_q,
	output logic             wake_request_q,
	output logic             watchdog_reset_q,
	output logic             por_hold_q
);

	// ==========================================================
	// Declarations
	// ==========================================================
	logic                                 ext_reset_n_sync;
	logic                                 ext_reset_active;
	logic                                 soft_clear;
	logic                                 chain_clear;
	logic [core_timer_pkg::CHAIN_W-1:0]   chain_q;
	logic                                 ovf_event;
	logic [core_timer_pkg::RATE_TAPS-1:0] tap_event;
	logic                                 rti_event;
	logic                                 wr_csr;
	logic                                 wr_wdog;
	logic                                 rd_csr;
	logic                                 rd_cnt;

	logic overflow_flag_q, overflow_flag_d;
	logic periodic_flag_q, periodic_flag_d;
	logic overflow_irq_enable_q, overflow_irq_enable_d;
	logic periodic_irq_enable_q, periodic_irq_enable_d;
	logic [1:0] rate_select_q, rate_select_d;
	logic [7:0] rdata_d;
	logic timer_irq_d;
	logic wake_request_d;

	logic [core_timer_pkg::WDOG_W-1:0] wdog_q, wdog_d;
	logic watchdog_fire;

	core_timer_pkg::por_state_t       por_state_q, por_state_d;
	logic [core_timer_pkg::POR_W-1:0] por_cnt_q, por_cnt_d;
	logic                             por_hold_d;

	// ==========================================================
	// External reset pin crossing
	// ==========================================================
	core_timer_sync2 #(
		.RESET_VAL (1'b1)
	) u_ext_reset_sync (
		.clock (clock),
		.reset (reset),
		.d     (ext_reset_n),
		.q     (ext_reset_n_sync)
	);

	// Internal reset from the pin or from a watchdog timeout
	assign ext_reset_active = ~ext_reset_n_sync;
	assign soft_clear       = ext_reset_active | watchdog_reset_q;
	assign chain_clear      = soft_clear | (por_state_q == core_timer_pkg::POR_FLUSH);

	// ==========================================================
	// Counter chain
	// ==========================================================
	core_timer_chain u_chain (
		.clock           (clock),
		.reset           (reset),
		.clear           (chain_clear),
		.clear_prescaler (stop_entry),
		.chain_q         (chain_q),
		.ovf_event       (ovf_event),
		.tap_event       (tap_event)
	);

	// Rate code indexes the tap; a change near a wrap may drop or add one event
	assign rti_event = tap_event[rate_select_q];

	// ==========================================================
	// Bus decode
	// ==========================================================
	assign wr_csr  = bus_write & core_timer_pkg::addr_is(bus_addr, core_timer_pkg::ADDR_CSR); // no cnt write
	assign wr_wdog = bus_write & core_timer_pkg::addr_is(bus_addr, core_timer_pkg::ADDR_WDOG);
	assign rd_csr  = bus_read & core_timer_pkg::addr_is(bus_addr, core_timer_pkg::ADDR_CSR);
	assign rd_cnt  = bus_read & core_timer_pkg::addr_is(bus_addr, core_timer_pkg::ADDR_CNT);

	// ==========================================================
	// Control/status next values
	// ==========================================================
	always_comb begin
		overflow_flag_d       = overflow_flag_q;
		periodic_flag_d       = periodic_flag_q;
		overflow_irq_enable_d = overflow_irq_enable_q;
		periodic_irq_enable_d = periodic_irq_enable_q;
		rate_select_d         = rate_select_q;
		if (wr_csr) begin
			// Flags ignore direct writes; clear bits act only on one
			if (bus_wdata[core_timer_pkg::CSR_OVF_CLEAR]) begin
				overflow_flag_d = 1'b0;
			end
			if (bus_wdata[core_timer_pkg::CSR_PER_CLEAR]) begin
				periodic_flag_d = 1'b0;
			end
			overflow_irq_enable_d = bus_wdata[core_timer_pkg::CSR_OVF_IRQ_EN];
			periodic_irq_enable_d = bus_wdata[core_timer_pkg::CSR_PER_IRQ_EN];
			rate_select_d = {bus_wdata[core_timer_pkg::CSR_RATE_HI], bus_wdata[core_timer_pkg::CSR_RATE_LO]};
		end
		// Setting after clearing so a coincident event survives
		if (ovf_event) begin
			overflow_flag_d = 1'b1;
		end
		if (rti_event) begin
			periodic_flag_d = 1'b1;
		end
		// Stop entry kills pending requests by dropping both enables
		if (stop_entry) begin
			overflow_irq_enable_d = 1'b0;
			periodic_irq_enable_d = 1'b0;
		end
		if (soft_clear) begin
			overflow_flag_d       = 1'b0;
			periodic_flag_d       = 1'b0;
			overflow_irq_enable_d = 1'b0;
			periodic_irq_enable_d = 1'b0;
			rate_select_d         = core_timer_pkg::RATE_RESET;
		end
	end

	// Interrupt request and wait wake-up follow the next flag state
	always_comb begin
		timer_irq_d = (overflow_flag_d & overflow_irq_enable_d) | (periodic_flag_d & periodic_irq_enable_d);
		wake_request_d = wait_mode & timer_irq_d;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			overflow_flag_q       <= 1'b0;
			periodic_flag_q       <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
			periodic_irq_enable_q <= 1'b0;
			rate_select_q         <= core_timer_pkg::RATE_RESET;
			timer_irq_q           <= 1'b0;
			wake_request_q        <= 1'b0;
		end else begin
			overflow_flag_q       <= overflow_flag_d;
			periodic_flag_q       <= periodic_flag_d;
			overflow_irq_enable_q <= overflow_irq_enable_d;
			periodic_irq_enable_q <= periodic_irq_enable_d;
			rate_select_q         <= rate_select_d;
			timer_irq_q           <= timer_irq_d;
			wake_request_q        <= wake_request_d;
		end
	end

	// ==========================================================
	// Read data, one cycle after the read strobe
	// ==========================================================
	always_comb begin
		rdata_d = 8'h00;
		if (rd_csr) begin
			rdata_d[core_timer_pkg::CSR_OVF_FLAG]   = overflow_flag_q;
			rdata_d[core_timer_pkg::CSR_PER_FLAG]   = periodic_flag_q;
			rdata_d[core_timer_pkg::CSR_OVF_IRQ_EN] = overflow_irq_enable_q;
			rdata_d[core_timer_pkg::CSR_PER_IRQ_EN] = periodic_irq_enable_q;
			rdata_d[core_timer_pkg::CSR_RATE_HI]    = rate_select_q[1];
			rdata_d[core_timer_pkg::CSR_RATE_LO]    = rate_select_q[0]; // clear bits stay zero
		end else if (rd_cnt) begin
			rdata_d = chain_q[core_timer_pkg::CNT_MSB:core_timer_pkg::CNT_LSB];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bus_rdata_q <= 8'h00;
		end else begin
			bus_rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Watchdog: divide-by-eight of periodic events
	// ==========================================================
	always_comb begin
		watchdog_fire = WATCHDOG_EN & rti_event & (wdog_q == core_timer_pkg::WDOG_LAST);
		wdog_d = wdog_q;
		if (rti_event) begin
			wdog_d = wdog_q + 3'h1;
		end
		// Service write restarts only this stage; it beats a coincident tick
		if (wr_wdog && !bus_wdata[core_timer_pkg::WDOG_SERVICE_BIT]) begin
			wdog_d        = '0;
			watchdog_fire = 1'b0;
		end
		if (soft_clear || !WATCHDOG_EN) begin
			wdog_d = '0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wdog_q           <= '0;
			watchdog_reset_q <= 1'b0;
		end else begin
			wdog_q           <= wdog_d;
			watchdog_reset_q <= watchdog_fire;
		end
	end

	// ==========================================================
	// Power-on delay: chain runs, then is flushed once before release
	// ==========================================================
	always_comb begin
		por_state_d = por_state_q;
		por_cnt_d   = por_cnt_q;
		unique case (por_state_q)
			core_timer_pkg::POR_COUNT: begin
				por_cnt_d = por_cnt_q + 12'h001;
				if (por_cnt_q == core_timer_pkg::POR_LAST) begin
					por_state_d = core_timer_pkg::POR_FLUSH;
				end
			end
			core_timer_pkg::POR_FLUSH: begin
				// An external reset still active keeps the device held
				if (!ext_reset_active) begin
					por_state_d = core_timer_pkg::POR_RUN;
				end
			end
			core_timer_pkg::POR_RUN: begin
				por_state_d = core_timer_pkg::POR_RUN;
			end
		endcase
		por_hold_d = (por_state_d != core_timer_pkg::POR_RUN);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			por_state_q <= core_timer_pkg::POR_COUNT;
			por_cnt_q   <= '0;
			por_hold_q  <= 1'b1;
		end else begin
			por_state_q <= por_state_d;
			por_cnt_q   <= por_cnt_d;
			por_hold_q  <= por_hold_d;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	chk_counter_read: assert property (@(posedge clock) disable iff (reset)
		rd_cnt |=> bus_rdata_q == $past(chain_q[9:2]))
		else $error("counter read does not return chain bits");

	chk_counter_readonly: assert property (@(posedge clock) disable iff (reset)
		(bus_write && bus_addr == core_timer_pkg::ADDR_CNT && !chain_clear && !stop_entry)
		|=> chain_q == 15'($past(chain_q) + 15'h0001))
		else $error("write to counter disturbed the chain");

	chk_overflow_set: assert property (@(posedge clock) disable iff (reset)
		(chain_q[9:0] == 10'h3ff && !chain_clear && !stop_entry) |=> overflow_flag_q)
		else $error("overflow flag missed a counter wrap");

	chk_overflow_hold: assert property (@(posedge clock) disable iff (reset)
		(overflow_flag_q && !soft_clear && !(wr_csr && bus_wdata[core_timer_pkg::CSR_OVF_CLEAR]))
		|=> overflow_flag_q)
		else $error("overflow flag cleared without a clear write");

	chk_clear_reads_zero: assert property (@(posedge clock) disable iff (reset)
		rd_csr |=> (bus_rdata_q[3:2] == 2'h0))
		else $error("flag clear bits read back nonzero");

	chk_irq_request: assert property (@(posedge clock) disable iff (reset)
		timer_irq_q == ((overflow_flag_q && overflow_irq_enable_q) || (periodic_flag_q && periodic_irq_enable_q)))
		else $error("interrupt request disagrees with flags and enables");

	chk_rate_tap: assert property (@(posedge clock) disable iff (reset)
		rti_event |-> (chain_q[11:0] == 12'hfff) && (rate_select_q != 2'h3 || chain_q[14:12] == 3'h7))
		else $error("periodic event off the selected tap");

	chk_rate_reset: assert property (@(posedge clock) disable iff (reset)
		soft_clear |=> rate_select_q == 2'h3 && !overflow_irq_enable_q && !periodic_irq_enable_q)
		else $error("internal reset left rate or enables wrong");

	chk_watchdog_timeout: assert property (@(posedge clock) disable iff (reset)
		watchdog_reset_q |-> $past(wdog_q) == 3'h7 && $past(rti_event))
		else $error("watchdog reset without eighth periodic event");

	chk_watchdog_service: assert property (@(posedge clock) disable iff (reset)
		(wr_wdog && !bus_wdata[0]) |=> wdog_q == 3'h0 && !watchdog_reset_q)
		else $error("watchdog service did not restart the stage");

	chk_por_release: assert property (@(posedge clock) disable iff (reset)
		(por_state_q == core_timer_pkg::POR_FLUSH) |-> por_cnt_q == core_timer_pkg::POR_CYCLES ##1 chain_q == 15'h0000)
		else $error("power-on flush at wrong count or chain not cleared");

	chk_ext_reset_clears: assert property (@(posedge clock) disable iff (reset)
		ext_reset_active |=> chain_q == 15'h0000 && !overflow_flag_q && !periodic_flag_q)
		else $error("external reset did not clear chain");

	chk_stop_entry: assert property (@(posedge clock) disable iff (reset)
		stop_entry |=> !overflow_irq_enable_q && !periodic_irq_enable_q && chain_q[1:0] == 2'h0 && !timer_irq_q)
		else $error("stop entry left timer interrupts armed");

	chk_wait_wake: assert property (@(posedge clock) disable iff (reset)
		wake_request_q |-> timer_irq_q && $past(wait_mode))
		else $error("wake request without wait and interrupt");

	chk_set_wins: assert property (@(posedge clock) disable iff (reset)
		(rti_event && wr_csr && bus_wdata[core_timer_pkg::CSR_PER_CLEAR]) |=> periodic_flag_q)
		else $error("periodic event lost to a coincident clear");

endmodule

`default_nettype wire

// [rtl/core_timer_pkg.sv]
// Package: register map, field layout and chain constants of the core timer
`default_nettype none

package core_timer_pkg;

	// ==========================================================
	// Register addresses on the internal bus
	// ==========================================================
	localparam logic [13:0] ADDR_CSR  = 14'h0008;
	localparam logic [13:0] ADDR_CNT  = 14'h0009;
	localparam logic [13:0] ADDR_WDOG = 14'h3ff0;

	// ==========================================================
	// Control/status field positions and reset values
	// ==========================================================
	localparam int CSR_OVF_FLAG   = 7;
	localparam int CSR_PER_FLAG   = 6;
	localparam int CSR_OVF_IRQ_EN = 5;
	localparam int CSR_PER_IRQ_EN = 4;
	localparam int CSR_OVF_CLEAR  = 3;
	localparam int CSR_PER_CLEAR  = 2;
	localparam int CSR_RATE_HI    = 1;
	localparam int CSR_RATE_LO    = 0;
	localparam logic [1:0] RATE_RESET = 2'h3;
	localparam int WDOG_SERVICE_BIT = 0;

	// ==========================================================
	// Counter chain layout
	// ==========================================================
	localparam int CHAIN_W   = 15;
	localparam int CNT_LSB   = 2;
	localparam int CNT_MSB   = 9;
	localparam int RATE_BASE = 11;
	localparam int RATE_TAPS = 4;
	localparam int WDOG_W    = 3;
	localparam logic [2:0] WDOG_LAST = 3'h7;

	// ==========================================================
	// Power-on delay: 4064 cycles, counted 0 .. 4063
	// ==========================================================
	localparam int POR_W = 12;
	localparam logic [11:0] POR_CYCLES = 12'hfe0;
	localparam logic [11:0] POR_LAST   = 12'hfdf;

	// ==========================================================
	// Power-on sequence states
	// ==========================================================
	typedef enum logic [2:0] {
		POR_COUNT = 3'h1,
		POR_FLUSH = 3'h2,
		POR_RUN   = 3'h4
	} por_state_t;

	// Address match, shared by read and write decoding
	function automatic logic addr_is(input logic [13:0] addr, input logic [13:0] target);
		return addr == target;
	endfunction

endpackage

`default_nettype wire

// [rtl/core_timer_sync2.sv]
// Module: two-flop synchroniser for one asynchronous level
`default_nettype none

module core_timer_sync2 #(
	parameter bit RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Level in and out
	input  wire logic d,
	output logic      q
);

	logic meta_q;

	// ==========================================================
	// Two stages; the first is read only by the second
	// ==========================================================
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_q <= RESET_VAL;
			q      <= RESET_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

// [rtl/core_timer_chain.sv]
// Module: binary counter chain with prescaler, overflow and periodic taps
`default_nettype none

module core_timer_chain (
	// Clock and reset
	input  wire logic                                clock,
	input  wire logic                                reset,
	// Clears
	input  wire logic                                clear,
	input  wire logic                                clear_prescaler,
	// Chain state and events
	output logic [core_timer_pkg::CHAIN_W-1:0]       chain_q,
	output logic                                     ovf_event,
	output logic [core_timer_pkg::RATE_TAPS-1:0]     tap_event
);

	logic [core_timer_pkg::CHAIN_W-1:0] chain_d;
	logic                               quiet;

	// ==========================================================
	// Chain next value: +1 each E cycle, bits 1:0 form the E/4 prescaler
	// ==========================================================
	always_comb begin
		chain_d = chain_q + 15'h0001;
		if (clear) begin
			chain_d = '0;
		end else if (clear_prescaler) begin
			chain_d[1:0] = 2'h0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			chain_q <= '0;
		end else begin
			chain_q <= chain_d;
		end
	end

	// ==========================================================
	// Events fire on the edge that wraps the lower bits; none while cleared
	// ==========================================================
	assign quiet     = ~clear & ~clear_prescaler;
	assign ovf_event = quiet & (&chain_q[core_timer_pkg::CNT_MSB:0]);

	// Periodic taps at 2^12 .. 2^15 E cycles
	generate
		for (genvar i = 0; i < core_timer_pkg::RATE_TAPS; i++) begin : g_tap
			assign tap_event[i] = quiet & (&chain_q[core_timer_pkg::RATE_BASE + i:0]);
		end
	endgenerate

endmodule

`default_nettype wire

// [verification/core_timer_tb.sv]
// Testbench: self-checking bench for the core timer
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals and counters
	// ==========================================================
	localparam logic [13:0] A_CSR = core_timer_pkg::ADDR_CSR;
	localparam logic [13:0] A_CNT = core_timer_pkg::ADDR_CNT;
	localparam logic [13:0] A_WDG = core_timer_pkg::ADDR_WDOG;
	logic        clock;
	logic        reset;
	logic        ext_reset_n;
	logic [13:0] bus_addr;
	logic        bus_write;
	logic        bus_read;
	logic [7:0]  bus_wdata;
	logic [7:0]  bus_rdata_q;
	logic        stop_entry;
	logic        wait_mode;
	logic        timer_irq_q;
	logic        wake_request_q;
	logic        watchdog_reset_q;
	logic        por_hold_q;
	int          n_errors;
	int          samples_checked;

	core_timer #(.WATCHDOG_EN(1'b1)) core_timer_i (
		.clock(clock), .reset(reset), .ext_reset_n(ext_reset_n),
		.bus_addr(bus_addr), .bus_write(bus_write), .bus_read(bus_read),
		.bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
		.stop_entry(stop_entry), .wait_mode(wait_mode),
		.timer_irq_q(timer_irq_q), .wake_request_q(wake_request_q),
		.watchdog_reset_q(watchdog_reset_q), .por_hold_q(por_hold_q)
	);

	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Write strobe held for exactly one taken edge
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_write <= 1'b1;
		@(posedge clock);
		bus_write <= 1'b0;
		#1;
	endtask

	// Read data lands on the taken edge, sampled just after it
	task automatic rd(input logic [13:0] a, output logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clock);
		bus_read <= 1'b0;
		#1;
		d = bus_rdata_q;
	endtask

	// Bounded wait for the interrupt level, counting edges
	task automatic wait_irq(input int limit, output int n);
		n = 0;
		while (timer_irq_q !== 1'b1 && n < limit) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (timer_irq_q !== 1'b1) check("irq_wait", 16'h0, 16'h1);
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic test_por();
		int n;
		logic [7:0] d;
		rd(A_CSR, d);
		check("csr_reset", 16'(d), 16'h03);
		@(posedge clock);
		#1;
		check("rdata_idle", 16'(bus_rdata_q), 16'h0);
		// Hold is timed from release; the read and idle check above spent three edges
		n = 3;
		while (por_hold_q === 1'b1 && n < 5000) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("por_len", 16'(n >= 4064 && n <= 4066), 16'h1);
		rd(A_CNT, d);
		check("cnt_after_por", 16'(d), 16'h0);
	endtask

	task automatic test_counter();
		logic [7:0] a, b, c;
		rd(A_CNT, a);
		repeat (6) @(posedge clock);
		rd(A_CNT, b);
		check("cnt_step", 16'(8'(b - a)), 16'h2);
		wr(A_CNT, 8'hff);
		repeat (4) @(posedge clock);
		rd(A_CNT, c);
		check("cnt_write_ignored", 16'(8'(c - b)), 16'h2);
		rd(A_WDG, a);
		rd(14'h0010, b);
		check("unmapped", 16'({a, b}), 16'h0);
	endtask

	task automatic test_csr();
		logic [7:0] d;
		wr(A_CSR, 8'h0f);
		rd(A_CSR, d);
		check("clear_bits_read0", 16'(d), 16'h03);
		wr(A_CSR, 8'hc3);
		rd(A_CSR, d);
		check("flags_not_writable", 16'(d), 16'h03);
		wr(A_CSR, 8'h32);
		rd(A_CSR, d);
		check("csr_layout", 16'(d), 16'h32);
	endtask

	task automatic test_overflow();
		int n;
		logic [7:0] d;
		wr(A_CSR, 8'h2b);
		@(posedge clock);
		wait_mode <= 1'b1;
		wait_irq(1100, n);
		check("wake", 16'(wake_request_q), 16'h1);
		rd(A_CSR, d);
		check("ovf_set", 16'(d & 8'hbf), 16'ha3);
		wr(A_CSR, 8'h23);
		check("zero_clear_kept", 16'(timer_irq_q), 16'h1);
		wr(A_CSR, 8'h2b);
		check("ovf_cleared", 16'(timer_irq_q), 16'h0);
		wait_irq(1100, n);
		check("ovf_period", 16'(n + 6), 16'd1024);
		// Stop entry drops the request but keeps the flag
		@(posedge clock);
		wait_mode  <= 1'b0;
		stop_entry <= 1'b1;
		@(posedge clock);
		stop_entry <= 1'b0;
		#1;
		check("stop_irq", 16'(timer_irq_q), 16'h0);
		rd(A_CSR, d);
		check("stop_csr", 16'(d & 8'hbf), 16'h83);
	endtask

	task automatic test_ext_reset();
		logic [7:0] d;
		wr(A_CSR, 8'h31);
		@(posedge clock);
		ext_reset_n <= 1'b0;
		repeat (4) @(posedge clock);
		ext_reset_n <= 1'b1;
		rd(A_CNT, d);
		check("ext_cnt", 16'(d), 16'h0);
		rd(A_CSR, d);
		check("ext_csr", 16'(d), 16'h03);
	endtask

	// Rate 2 and 3 intervals are too long for the run; only readback
	task automatic test_periodic();
		int n;
		logic [7:0] d;
		for (int r = 0; r < 2; r++) begin
			wr(A_WDG, 8'h00);
			wr(A_CSR, 8'(8'h14 | r));
			wait_irq((1 << (12 + r)) + 20, n);
			wr(A_CSR, 8'(8'h14 | r));
			check("per_cleared", 16'(timer_irq_q), 16'h0);
			wait_irq((1 << (12 + r)) + 20, n);
			check("per_period", 16'(n + 2), 16'(1 << (12 + r)));
		end
		wr(A_CSR, 8'h02);
		rd(A_CSR, d);
		check("rate_two", 16'(d & 8'h3f), 16'h02);
	endtask

	task automatic test_watchdog();
		int n;
		logic [7:0] d;
		wr(A_CSR, 8'h00);
		wr(A_WDG, 8'h00);
		n = 0;
		while (watchdog_reset_q !== 1'b1 && n < 33000) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("wdog_time", 16'(n > 7 * 4096 && n <= 8 * 4096 + 4), 16'h1);
		rd(A_CSR, d);
		check("wdog_reset", 16'(d), 16'h03);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	// ==========================================================
	initial begin
		n_errors        = 0;
		samples_checked = 0;
		reset       = 1'b1;
		ext_reset_n = 1'b1;
		bus_addr    = 14'h0000;
		bus_write   = 1'b0;
		bus_read    = 1'b0;
		bus_wdata   = 8'h00;
		stop_entry  = 1'b0;
		wait_mode   = 1'b0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		test_por();
		test_counter();
		test_csr();
		test_overflow();
		test_ext_reset();
		test_periodic();
		test_watchdog();
		summarize();
	end

	// Cuts a hang well past the expected run length
	initial begin
		repeat (90000) @(posedge clock);
		check("run_timeout", 16'h0, 16'h1);
		summarize();
	end
endmodule

`default_nettype wire
